// ---- design/ctlp_cal_ctrl.sv ----
// module: calibration trigger, status pin and low-power control
// ======================================================================
// Summary of operation
// - status pin follows foreground done, stopped or alarm per select
// - select code 3 holds the status pin low
// - trigger source 0 uses software bit, hardware pin ignored
// - trigger source 1 uses hardware pin, software bit ignored
// - software trigger bit 0 acts as the hardware pin level
// - autonomous sleep lasts (2^k+1)*256 clocks, k from 3-bit code
// - wake settling lasts (2^k+1)*256 clocks, k from 2-bit code
// - trigger mode 0 times sleep with the sleep counter
// - trigger mode 1 sleeps until the selected trigger is low
// - low-power cycle runs only with low-power and background enabled
// - calibration data access allowed only while enable bit set
// - foreground done flag sets on completion or skip
// - stopped flag follows halt; without background, follows done
//
// The strobed register port was left to the implementer.
`default_nettype none
module ctlp_cal_ctrl #(
  parameter int P_DELAY_UNIT = ctlp_pkg::DELAY_UNIT
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_b,
  input  wire logic [ctlp_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [ctlp_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output logic      [ctlp_pkg::DATA_W-1:0]  o_rdata,
  input  wire logic                         i_hw_trigger_pin,
  output logic                              o_cal_status_pin,
  input  wire ctlp_pkg::ctlp_cal_evt_s      i_cal_evt,
  input  wire logic                         i_background_cal_enable,
  input  wire logic                         i_lp_cal_done,
  output logic                              o_cal_trigger,
  output logic                              o_converter_asleep,
  output logic                              o_lp_cal_request,
  input  wire logic [ctlp_pkg::DATA_W-1:0]  i_cal_data,
  output logic      [ctlp_pkg::DATA_W-1:0]  o_cal_data_wdata,
  output logic                              o_cal_data_wr,
  output logic                              o_cal_data_rd
);
  import ctlp_pkg::*;

  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] UNIT     = CNT_W'(P_DELAY_UNIT);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // ====================================================================
  // register state
  logic [DATA_W-1:0] pin_cfg_reg;
  logic [DATA_W-1:0] soft_trig_reg;
  logic [DATA_W-1:0] lp_cfg_reg;
  logic [DATA_W-1:0] data_en_reg;
  logic              fg_finish_reg;
  logic              stopped_reg;
  logic              stopped_next;
  logic              fg_finish_next;
  ctlp_lp_state_e    lp_state_reg;
  ctlp_lp_state_e    lp_state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [DATA_W-1:0] rdata_next;
  logic              hw_trig_sync;

  // ====================================================================
  // bus decode
  wire wr_pin_cfg   = i_wr && (i_addr == ADDR_PIN_CFG);
  wire wr_soft_trig = i_wr && (i_addr == ADDR_SOFT_TRIG);
  wire wr_lp_cfg    = i_wr && (i_addr == ADDR_LP_CFG);
  wire wr_data_en   = i_wr && (i_addr == ADDR_DATA_EN);
  wire hit_cal_data = i_addr == ADDR_CAL_DATA;

  // ====================================================================
  // field views
  wire       trig_src  = pin_cfg_reg[POS_TRIG_SRC];
  wire [1:0] stat_sel  = pin_cfg_reg[POS_STAT_SEL_HI:POS_STAT_SEL_LO];
  wire       soft_trig = soft_trig_reg[POS_SOFT_TRIG];
  wire       lp_enable  = lp_cfg_reg[POS_LP_ENABLE];
  wire       trig_sleep = lp_cfg_reg[POS_TRIG_SLEEP];
  wire [1:0] wake_code = lp_cfg_reg[POS_WAKE_HI:POS_WAKE_LO];
  wire [2:0] sleep_code = lp_cfg_reg[POS_SLEEP_HI:POS_SLEEP_LO];
  wire       data_en   = data_en_reg[POS_DATA_EN];

  // ====================================================================
  // trigger source
  ctlp_sync u_trig_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_level (i_hw_trigger_pin),
    .o_level (hw_trig_sync)
  );

  wire sel_trigger = trig_src ? hw_trig_sync : soft_trig;

  // ====================================================================
  // status flags
  // done on completion or skip; set wins over restart
  always_comb begin
    fg_finish_next = fg_finish_reg;
    if (i_cal_evt.fg_restart) begin
      fg_finish_next = 1'b0;
    end
    if (i_cal_evt.fg_complete) begin
      fg_finish_next = 1'b1;
    end
  end

  // stopped follows halt, or done when background is off
  always_comb begin
    if (i_background_cal_enable) begin
      stopped_next = i_cal_evt.bg_halted;
    end else begin
      stopped_next = fg_finish_next;
    end
  end

  logic stat_mux;
  always_comb begin
    unique case (stat_sel)
      SEL_FG_FINISH: stat_mux = fg_finish_reg;
      SEL_STOPPED: stat_mux = stopped_reg;
      SEL_ALARM:   stat_mux = i_cal_evt.alarm;
      SEL_LOW:     stat_mux = 1'b0;
    endcase
  end

  // ====================================================================
  // low-power sleep and wake sequencing
  function automatic logic [CNT_W-1:0] delay_of(input logic [K_W-1:0] k);
    delay_of = ((CNT_ONE << k) + CNT_ONE) * UNIT;
  endfunction

  wire [CNT_W-1:0] sleep_load = delay_of(SLEEP_K[sleep_code]) - CNT_ONE;
  wire [CNT_W-1:0] wake_load  = delay_of(WAKE_K[wake_code]) - CNT_ONE;
  wire             lp_active  = lp_enable && i_background_cal_enable;
  wire             cnt_done   = cnt_reg == CNT_ZERO;
  wire [CNT_W-1:0] cnt_dec    = cnt_reg - CNT_ONE;

  always_comb begin
    lp_state_next = lp_state_reg;
    cnt_next      = cnt_reg;
    if (!lp_active) begin
      lp_state_next = LP_IDLE;
      cnt_next      = CNT_ZERO;
    end else begin
      unique case (lp_state_reg)
        LP_IDLE: begin
          lp_state_next = LP_SLEEP;
          cnt_next      = sleep_load;
        end
        LP_SLEEP: begin
          // triggered mode waits for a low trigger
          if (trig_sleep) begin
            if (!sel_trigger) begin
              lp_state_next = LP_WAKE;
              cnt_next      = wake_load;
            end
          // autonomous mode times out on the counter
          end else if (cnt_done) begin
            lp_state_next = LP_WAKE;
            cnt_next      = wake_load;
          end else begin
            cnt_next = cnt_dec;
          end
        end
        LP_WAKE: begin
          if (cnt_done) begin
            lp_state_next = LP_CAL;
          end else begin
            cnt_next = cnt_dec;
          end
        end
        LP_CAL: begin
          if (i_lp_cal_done) begin
            lp_state_next = LP_SLEEP;
            cnt_next      = sleep_load;
          end
        end
      endcase
    end
  end

  // ====================================================================
  // read path; unmapped addresses read zero
  // data port reads zero while access is disabled
  wire [DATA_W-1:0] cal_data_rd = data_en ? i_cal_data : DATA_ZERO;
  wire [DATA_W-1:0] status_rd   = {{(DATA_W-2){1'b0}}, stopped_reg,
                                   fg_finish_reg};

  always_comb begin
    rdata_next = DATA_ZERO;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_CAL_STATUS: rdata_next = status_rd;
        ADDR_PIN_CFG:    rdata_next = pin_cfg_reg;
        ADDR_SOFT_TRIG:  rdata_next = soft_trig_reg;
        ADDR_LP_CFG:     rdata_next = lp_cfg_reg;
        ADDR_DATA_EN:    rdata_next = data_en_reg;
        ADDR_CAL_DATA:   rdata_next = cal_data_rd;
        default:         rdata_next = DATA_ZERO;
      endcase
    end
  end

  // ====================================================================
  // registers
  // configuration resets to the recommended codes
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pin_cfg_reg   <= RST_PIN_CFG;
      soft_trig_reg <= RST_SOFT_TRIG;
      lp_cfg_reg    <= RST_LP_CFG;
      data_en_reg   <= RST_DATA_EN;
    end else begin
      if (wr_pin_cfg) pin_cfg_reg <= i_wdata;
      if (wr_soft_trig) soft_trig_reg <= i_wdata;
      if (wr_lp_cfg) lp_cfg_reg <= i_wdata;
      if (wr_data_en) data_en_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      fg_finish_reg <= 1'b0;
      stopped_reg  <= 1'b0;
      lp_state_reg <= LP_IDLE;
      cnt_reg      <= '0;
    end else begin
      fg_finish_reg <= fg_finish_next;
      stopped_reg  <= stopped_next;
      lp_state_reg <= lp_state_next;
      cnt_reg      <= cnt_next;
    end
  end

  // outputs are all registered; the pin lags its source by one clock
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rdata            <= DATA_ZERO;
      o_cal_status_pin   <= 1'b0;
      o_cal_trigger      <= 1'b0;
      o_converter_asleep <= 1'b0;
      o_lp_cal_request   <= 1'b0;
    end else begin
      o_rdata            <= rdata_next;
      o_cal_status_pin   <= stat_mux;
      o_cal_trigger      <= sel_trigger;
      o_converter_asleep <= lp_state_next == LP_SLEEP;
      o_lp_cal_request   <= lp_state_next == LP_CAL;
    end
  end

  // data port strobes gated by the enable
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_cal_data_wr    <= 1'b0;
      o_cal_data_rd    <= 1'b0;
      o_cal_data_wdata <= DATA_ZERO;
    end else begin
      o_cal_data_wr    <= i_wr && hit_cal_data && data_en;
      o_cal_data_rd    <= i_rd && hit_cal_data && data_en;
      o_cal_data_wdata <= i_wdata;
    end
  end

  // ====================================================================
  // checks
  a_stat_pin_low: assert property (
    stat_sel == SEL_LOW |=> !o_cal_status_pin)
    else $error("status pin not low under select code 3");

  a_stat_pin_src: assert property (
    stat_sel == SEL_STOPPED |=> o_cal_status_pin == $past(stopped_reg))
    else $error("status pin does not mirror stopped flag");

  a_stat_pin_done: assert property (
    stat_sel == SEL_FG_FINISH |=> o_cal_status_pin == $past(fg_finish_reg))
    else $error("status pin does not mirror foreground done flag");

  a_stat_pin_alarm: assert property (
    stat_sel == SEL_ALARM |=> o_cal_status_pin == $past(i_cal_evt.alarm))
    else $error("status pin does not mirror alarm flag");

  a_trig_soft: assert property (
    !trig_src ##1 !$past(trig_src) |-> o_cal_trigger == $past(soft_trig))
    else $error("software trigger not used under source 0");

  a_trig_hw: assert property (
    trig_src |=> o_cal_trigger == $past(hw_trig_sync))
    else $error("hardware trigger not used under source 1");

  a_sleep_time: assert property (
    lp_state_reg == LP_SLEEP && !trig_sleep && cnt_done && lp_active
    |=> lp_state_reg == LP_WAKE && cnt_reg == $past(wake_load))
    else $error("autonomous sleep did not end into wake");

  a_sleep_hold: assert property (
    lp_state_reg == LP_SLEEP && trig_sleep && sel_trigger && lp_active
    |=> lp_state_reg == LP_SLEEP)
    else $error("triggered sleep woke with trigger high");

  a_lp_entry: assert property (
    lp_state_reg == LP_IDLE && lp_active
    |=> lp_state_reg == LP_SLEEP && o_converter_asleep)
    else $error("low-power cycle did not start in sleep");

  a_wake_settle: assert property (
    lp_state_reg == LP_WAKE && cnt_done && lp_active
    |=> lp_state_reg == LP_CAL && o_lp_cal_request)
    else $error("wake settling did not end into calibration");

  a_lp_inactive: assert property (
    !lp_active |=> lp_state_reg == LP_IDLE && !o_converter_asleep
      && !o_lp_cal_request)
    else $error("low-power cycle active while disabled");

  a_data_gate: assert property (
    (o_cal_data_wr || o_cal_data_rd) |-> $past(data_en))
    else $error("calibration data strobe without access enable");

  a_fg_finish_set: assert property (
    i_cal_evt.fg_complete |=> fg_finish_reg ##1
      (o_cal_status_pin || $past(stat_sel) != SEL_FG_FINISH))
    else $error("foreground done flag missed a completion");

  a_fg_finish_clr: assert property (
    i_cal_evt.fg_restart && !i_cal_evt.fg_complete |=> !fg_finish_reg)
    else $error("foreground done flag not cleared by restart");

  a_stop_no_bg: assert property (
    !i_background_cal_enable |=> stopped_reg == fg_finish_reg)
    else $error("stopped flag does not follow done without background");

  a_stop_follow: assert property (
    i_background_cal_enable |=> stopped_reg == $past(i_cal_evt.bg_halted))
    else $error("stopped flag does not follow the halt state");
endmodule
`default_nettype wire

// ---- design/ctlp_pkg.sv ----
// package: constants and types of the calibration control block
`default_nettype none
package ctlp_pkg;
  // ====================================================================
  // register map and bus
  localparam int            ADDR_W          = 8;
  localparam int            DATA_W          = 8;
  localparam logic [7:0]    ADDR_CAL_STATUS = 8'h6a;
  localparam logic [7:0]    ADDR_PIN_CFG    = 8'h6b;
  localparam logic [7:0]    ADDR_SOFT_TRIG  = 8'h6c;
  localparam logic [7:0]    ADDR_LP_CFG     = 8'h6e;
  localparam logic [7:0]    ADDR_DATA_EN    = 8'h70;
  localparam logic [7:0]    ADDR_CAL_DATA   = 8'h71;
  localparam logic [7:0]    RST_PIN_CFG     = 8'h00;
  localparam logic [7:0]    RST_SOFT_TRIG   = 8'h01;
  localparam logic [7:0]    RST_LP_CFG      = 8'h88;
  localparam logic [7:0]    RST_DATA_EN     = 8'h00;
  localparam logic [7:0]    DATA_ZERO       = 8'h00;
  // ====================================================================
  // field positions
  localparam int            POS_TRIG_SRC    = 0;
  localparam int            POS_STAT_SEL_LO = 1;
  localparam int            POS_STAT_SEL_HI = 2;
  localparam int            POS_SOFT_TRIG   = 0;
  localparam int            POS_LP_ENABLE   = 0;
  localparam int            POS_TRIG_SLEEP  = 1;
  localparam int            POS_WAKE_LO     = 3;
  localparam int            POS_WAKE_HI     = 4;
  localparam int            POS_SLEEP_LO    = 5;
  localparam int            POS_SLEEP_HI    = 7;
  localparam int            POS_DATA_EN     = 0;
  // ====================================================================
  // status pin select codes
  localparam logic [1:0]    SEL_FG_FINISH   = 2'h0;
  localparam logic [1:0]    SEL_STOPPED     = 2'h1;
  localparam logic [1:0]    SEL_ALARM       = 2'h2;
  localparam logic [1:0]    SEL_LOW         = 2'h3;
  // ====================================================================
  // timing: delays are (2^k + 1) * 256 sample clock periods
  localparam int            CLK_PERIOD_NS   = 4;
  localparam int            DELAY_UNIT      = 256;
  localparam int            CNT_W           = 42;
  localparam int            K_W             = 6;
  localparam logic [K_W-1:0] SLEEP_K [8] = '{6'h03, 6'h0f, 6'h12, 6'h15,
                                              6'h18, 6'h1b, 6'h1e, 6'h21};
  localparam logic [K_W-1:0] WAKE_K [4]  = '{6'h03, 6'h12, 6'h15, 6'h18};
  // ====================================================================
  // types
  typedef enum logic [1:0] {
    LP_IDLE,
    LP_SLEEP,
    LP_WAKE,
    LP_CAL
  } ctlp_lp_state_e;

  typedef struct packed {
    logic fg_complete;
    logic fg_restart;
    logic bg_halted;
    logic alarm;
  } ctlp_cal_evt_s;
endpackage
`default_nettype wire

// ---- design/ctlp_sync.sv ----
// module: two flip-flop synchroniser for a level input
`default_nettype none
module ctlp_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_level,
  output logic      o_level
);
  logic meta_reg;

  // ====================================================================
  // two-stage synchroniser
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_reg <= 1'b0;
      o_level  <= 1'b0;
    end else begin
      meta_reg <= i_level;
      o_level  <= meta_reg;
    end
  end

  a_sync_latency: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_level) |-> $past(i_level, 2))
    else $error("synchroniser output rose without input two cycles back");
endmodule
`default_nettype wire

// ---- testbench/ctlp_cal_ctrl_tb.sv ----
// bench: self-checking test of the calibration control block
`default_nettype none
module ctlp_cal_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ctlp_pkg::*;
  // ====================================================================
  // signals
  localparam int DU = 1;
  logic          clk, rst_b, wr, rd, hw_pin, stat_pin, bg_en, lp_done;
  logic          trig, asleep, lpreq, cwr, crd, want, seen, wstb, rstb;
  logic [7:0]    addr, wdata, rdata, cdata, cwdata;
  ctlp_cal_evt_s evt;
  int            errors, cmp_count;

  ctlp_cal_ctrl #(.P_DELAY_UNIT(DU)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_hw_trigger_pin(hw_pin),
    .o_cal_status_pin(stat_pin), .i_cal_evt(evt),
    .i_background_cal_enable(bg_en), .i_lp_cal_done(lp_done),
    .o_cal_trigger(trig), .o_converter_asleep(asleep),
    .o_lp_cal_request(lpreq), .i_cal_data(cdata),
    .o_cal_data_wdata(cwdata), .o_cal_data_wr(cwr), .o_cal_data_rd(crd));

  ctlp_ext_ctrl ext (.i_clk(clk), .i_want_trigger(want),
    .i_cal_status_pin(stat_pin), .o_hw_trigger_pin(hw_pin),
    .o_status_seen(seen));
  // ====================================================================
  // shared tasks
  task automatic close_out();
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [63:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bw(input logic [7:0] a, d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    wstb = cwr;
  endtask
  task automatic rchk(input logic [7:0] a, e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rstb = crd;
    check("rdata", e, rdata);
  endtask
  task automatic pulse(input logic done_p, fg_p, rs_p);
    @(posedge clk);
    lp_done         <= done_p;
    evt.fg_complete <= fg_p;
    evt.fg_restart  <= rs_p;
    @(posedge clk);
    lp_done         <= 1'b0;
    evt.fg_complete <= 1'b0;
    evt.fg_restart  <= 1'b0;
    tick(3);
  endtask
  // counts cycles while asleep (w=0) or request (w=1) equals v
  task automatic run_len(input int w, input logic v, output int n);
    n = 0;
    while ((w == 0 ? asleep : lpreq) === v) begin
      n++;
      tick(1);
      if (n > 40000) begin
        errors++;
        $display("ERROR wait expected %0d seen %0d", 40000, n);
        close_out();
      end
    end
  endtask
  // ====================================================================
  // scenarios
  task automatic t_reset();
    rchk(ADDR_PIN_CFG, 8'h00);
    rchk(ADDR_SOFT_TRIG, 8'h01);
    rchk(ADDR_LP_CFG, 8'h88);
    rchk(ADDR_DATA_EN, 8'h00);
    bw(ADDR_CAL_STATUS, 8'hff);
    rchk(ADDR_CAL_STATUS, 8'h00);
    bw(8'h55, 8'hff);
    rchk(8'h55, 8'h00);
  endtask
  task automatic t_trig_src();
    @(posedge clk);
    want <= 1'b0;
    tick(5);
    check("trigger", 1, trig);
    bw(ADDR_SOFT_TRIG, 8'h00);
    tick(1);
    check("trigger", 0, trig);
    @(posedge clk);
    want <= 1'b1;
    tick(5);
    check("trigger", 0, trig);
    bw(ADDR_PIN_CFG, 8'h01);
    tick(5);
    check("trigger", 1, trig);
    bw(ADDR_SOFT_TRIG, 8'h01);
    want <= 1'b0;
    tick(5);
    check("trigger", 0, trig);
    bw(ADDR_PIN_CFG, 8'h00);
    want <= 1'b1;
  endtask
  task automatic mux_pass(input logic [3:0] e);
    for (int c = 0; c < 4; c++) begin
      bw(ADDR_PIN_CFG, {5'h00, c[1:0], 1'b0});
      tick(4);
      check("status_pin", e[c], seen);
    end
  endtask
  task automatic t_status();
    pulse(1'b0, 1'b1, 1'b0);
    rchk(ADDR_CAL_STATUS, 8'h03);
    mux_pass(4'b0011);
    @(posedge clk);
    bg_en     <= 1'b1;
    evt.alarm <= 1'b1;
    mux_pass(4'b0101);
    @(posedge clk);
    evt.alarm     <= 1'b0;
    evt.bg_halted <= 1'b1;
    pulse(1'b0, 1'b0, 1'b1);
    mux_pass(4'b0010);
    @(posedge clk);
    evt.bg_halted <= 1'b0;
    tick(2);
    rchk(ADDR_CAL_STATUS, 8'h00);
    bw(ADDR_PIN_CFG, 8'h00);
  endtask
  task automatic t_data();
    rchk(ADDR_CAL_DATA, 8'h00);
    check("data_rd", 0, rstb);
    bw(ADDR_CAL_DATA, 8'h3c);
    check("data_wr", 0, wstb);
    bw(ADDR_DATA_EN, 8'h01);
    rchk(ADDR_CAL_DATA, 8'h5a);
    check("data_rd", 1, rstb);
    bw(ADDR_CAL_DATA, 8'h3c);
    check("data_wr", 1, wstb);
    check("data_wdata", 8'h3c, cwdata);
    bw(ADDR_DATA_EN, 8'h00);
  endtask
  task automatic t_auto();
    int n;
    for (int c = 0; c < 2; c++) begin
      bw(ADDR_LP_CFG, 8'h00);
      tick(2);
      check("asleep", 0, asleep);
      bw(ADDR_LP_CFG, {c[2:0], 5'h01});
      run_len(0, 1'b0, n);
      run_len(0, 1'b1, n);
      check("sleep_len", ((1 << SLEEP_K[c]) + 1) * DU, n);
      run_len(1, 1'b0, n);
      check("wake_len", ((1 << WAKE_K[0]) + 1) * DU, n);
      pulse(1'b1, 1'b0, 1'b0);
      run_len(1, 1'b1, n);
      run_len(0, 1'b0, n);
    end
  endtask
  task automatic t_trig_sleep();
    int n;
    bw(ADDR_LP_CFG, 8'h00);
    tick(2);
    bw(ADDR_LP_CFG, 8'h03);
    tick(40);
    check("asleep", 1, asleep);
    bw(ADDR_SOFT_TRIG, 8'h00);
    run_len(0, 1'b1, n);
    run_len(1, 1'b0, n);
    check("wake_len", ((1 << WAKE_K[0]) + 1) * DU, n);
    bw(ADDR_SOFT_TRIG, 8'h01);
    pulse(1'b1, 1'b0, 1'b0);
    bw(ADDR_LP_CFG, 8'h00);
    @(posedge clk);
    bg_en <= 1'b0;
    bw(ADDR_LP_CFG, 8'h01);
    tick(30);
    check("asleep", 0, asleep);
    check("request", 0, lpreq);
  endtask
  // every code loads its own delay; long ones are read at the load
  task automatic t_codes();
    logic [63:0] e;
    bw(ADDR_SOFT_TRIG, 8'h00);
    for (int s = 0; s < 8; s++) begin
      bw(ADDR_LP_CFG, 8'h00);
      tick(2);
      bw(ADDR_LP_CFG, {s[2:0], s[1:0], 3'b011});
      tick(1);
      e = ((64'd1 << SLEEP_K[s]) + 64'd1) * DU - 64'd1;
      check("sleep_cnt", e, dut.cnt_reg);
      tick(1);
      e = ((64'd1 << WAKE_K[s[1:0]]) + 64'd1) * DU - 64'd1;
      check("wake_cnt", e, dut.cnt_reg);
    end
    bw(ADDR_LP_CFG, 8'h00);
    bw(ADDR_SOFT_TRIG, 8'h01);
  endtask
  // a reset in mid-run restores every register
  task automatic t_reset_mid();
    bw(ADDR_PIN_CFG, 8'h07);
    bw(ADDR_DATA_EN, 8'h01);
    @(posedge clk);
    rst_b <= 1'b0;
    tick(3);
    check("rdata", 0, rdata);
    @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    check("trigger", 1, trig);
    check("asleep", 0, asleep);
    rchk(ADDR_PIN_CFG, 8'h00);
    rchk(ADDR_SOFT_TRIG, 8'h01);
    rchk(ADDR_LP_CFG, 8'h88);
    rchk(ADDR_DATA_EN, 8'h00);
  endtask
  // ====================================================================
  // clock, reset and sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    {wr, rd, bg_en, lp_done, addr, wdata} = '0;
    evt   = '0;
    cdata = 8'h5a;
    want  = 1'b1;
    errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    t_reset();
    t_trig_src();
    t_status();
    t_data();
    t_auto();
    t_codes();
    t_trig_sleep();
    t_reset_mid();
    close_out();
  end
endmodule
`default_nettype wire

// ---- testbench/ctlp_ext_ctrl.sv ----
// partner: external controller on the trigger and status pins
`default_nettype none
module ctlp_ext_ctrl (
  input  wire logic i_clk,
  input  wire logic i_want_trigger,
  input  wire logic i_cal_status_pin,
  output var logic  o_hw_trigger_pin,
  output var logic  o_status_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====================================================================
  // pin levels
  // trigger idles high
  // one process owns both pins; levels move just after an edge
  initial begin
    o_hw_trigger_pin = 1'b1;
    o_status_seen    = 1'b0;
    forever begin
      @(posedge i_clk);
      o_hw_trigger_pin <= i_want_trigger;
      o_status_seen    <= i_cal_status_pin;
    end
  end
endmodule
`default_nettype wire
